// file: common/gpx_pkg.sv
// Purpose: Shared constants for the GPIO port block with alternate functions.
// Assumes: Word-wide register accesses over the on-chip special-function and extension buses.
// Notes: Register offsets are byte addresses as printed; all ports reset to inputs.
package gpx_pkg;
  // -------------------------------------------------------------------------
  // Register offsets.
  // -------------------------------------------------------------------------
  localparam logic [19:0] ADDR_PWM_CC_PORT_DATA = 20'h0FFD0;
  localparam logic [19:0] ADDR_PWM_CC_PORT_DIRECTION = 20'h0FFD2;
  localparam logic [19:0] ADDR_PWM_CC_PORT_OPEN_DRAIN = 20'h0F1D2;
  localparam logic [19:0] ADDR_CC_PORT_DATA = 20'hFFD40;
  localparam logic [19:0] ADDR_CC_PORT_DIRECTION = 20'h0FFD6;
  localparam logic [19:0] ADDR_CC_PORT_OPEN_DRAIN = 20'h0F1D6;
  localparam logic [19:0] ADDR_EXT_PORT_DATA = 20'h0C100;
  localparam logic [19:0] ADDR_EXT_PORT_DATA_SET = 20'h0C102;
  localparam logic [19:0] ADDR_EXT_PORT_DATA_CLEAR = 20'h0C104;
  localparam logic [19:0] ADDR_EXT_PORT_DIRECTION = 20'h0C200;
  localparam logic [19:0] ADDR_EXT_PORT_DIRECTION_SET = 20'h0C202;
  localparam logic [19:0] ADDR_EXT_PORT_DIRECTION_CLEAR = 20'h0C204;
  localparam logic [19:0] ADDR_EXT_PORT_OPEN_DRAIN = 20'h0C300;
  localparam logic [19:0] ADDR_EXT_PORT_OPEN_DRAIN_SET = 20'h0C302;
  localparam logic [19:0] ADDR_EXT_PORT_OPEN_DRAIN_CLEAR = 20'h0C304;
  // -------------------------------------------------------------------------
  // Reset values and widths.
  // -------------------------------------------------------------------------
  localparam logic [7:0] RESET_SMALL = 8'h00;
  localparam logic [15:0] RESET_EXT = 16'h0000;
  // Capture input sampling: 200 ns interval.
  localparam int SAMPLE_NS = 200;
  localparam int CLK_NS = 5;
  localparam int SAMPLE_CYCLES = SAMPLE_NS / CLK_NS;
  localparam logic [5:0] SAMPLE_LAST = 6'(SAMPLE_CYCLES - 1);
endpackage

// file: src/gpx_pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement of the last two stages.
// Assumes: Inputs come from pins, asynchronous to clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module gpx_pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  // -------------------------------------------------------------------------
  // State.
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } gpx_sync_type;
  gpx_sync_type st_q;
  gpx_sync_type st_d;

  // Shift the stages; the level moves only where stages two and three agree.
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // Where the stages agree the level follows them, falling as well as rising; otherwise it holds.
    st_d.lvl = (st_q.s2 & ~(st_q.s2 ^ st_q.s3)) | (st_q.lvl & (st_q.s2 ^ st_q.s3));
  end

  // Register the stages, frozen while the enable is low.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.lvl;
endmodule // gpx_pin_sync

// file: src/gpx_ports.sv
// Purpose: Two 8-bit ports and one 16-bit extension port with alternate functions.
// Assumes: Single clock; word-wide register writes; pins resolved outside from enables.
// Notes: Capture/compare and PWM units are outside; this block merges their outputs at the pins or the second port latch and samples their capture inputs.
`timescale 1ns/1ps
module gpx_ports (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [19:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  input wire logic extension_peripheral_enable,
  input wire logic extension_port_enable,
  input wire logic [3:0] pwm_channel_out,
  input wire logic [3:0] cc_hi_alt_out,
  input wire logic [3:0] cc_hi_alt_en,
  input wire logic [7:0] cc_port_alt_out,
  input wire logic [7:0] cc_port_alt_load,
  output logic [3:0] cc_hi_capture_in,
  output logic [7:0] cc_port_capture_in,
  input wire logic [7:0] pwm_cc_pin_in,
  output logic [7:0] pwm_cc_pin_out,
  output logic [7:0] pwm_cc_pin_oe,
  input wire logic [7:0] cc_pin_in,
  output logic [7:0] cc_pin_out,
  output logic [7:0] cc_pin_oe,
  input wire logic [15:0] ext_pin_in,
  output logic [15:0] ext_pin_out,
  output logic [15:0] ext_pin_oe
);
  // -------------------------------------------------------------------------
  // State.
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] p7_data;
    logic [7:0] p7_dir;
    logic [7:0] p7_od;
    logic [7:0] p8_data;
    logic [7:0] p8_dir;
    logic [7:0] p8_od;
    logic [15:0] x_data;
    logic [15:0] x_dir;
    logic [15:0] x_od;
    logic [5:0] samp_cnt;
    logic [3:0] cap_hi;
    logic [7:0] cap_lo;
    logic [15:0] rdata;
    logic hit;
  } gpx_state_type;
  gpx_state_type st_q;
  gpx_state_type st_d;

  // Synchronised pin levels.
  logic [7:0] p7_lvl;
  logic [7:0] p8_lvl;
  logic [15:0] x_lvl;
  // Extension port usable only with both enables.
  logic x_en;
  // High when the address names one of the nine extension port registers.
  logic x_map;
  // Desired output value per line, before the driver mode is applied.
  logic [7:0] p7_val;
  logic [7:0] p8_val;
  logic [15:0] x_val;

  // -------------------------------------------------------------------------
  // Pin synchronisers.
  // -------------------------------------------------------------------------
  gpx_pin_sync #(.WIDTH(8)) u_sync7 (.clk(clk), .srst(srst), .ce(ce), .pin_in(pwm_cc_pin_in), .level_out(p7_lvl));
  gpx_pin_sync #(.WIDTH(8)) u_sync8 (.clk(clk), .srst(srst), .ce(ce), .pin_in(cc_pin_in), .level_out(p8_lvl));
  gpx_pin_sync #(.WIDTH(16)) u_sync9 (.clk(clk), .srst(srst), .ce(ce), .pin_in(ext_pin_in), .level_out(x_lvl));

  assign x_en = extension_peripheral_enable & extension_port_enable;

  // Decode the extension register family once, so that a miss on the small ports falls back to it.
  // Without this decode an enabled extension port would answer every address, mapped or not.
  assign x_map = reg_addr inside {gpx_pkg::ADDR_EXT_PORT_DATA, gpx_pkg::ADDR_EXT_PORT_DATA_SET,
    gpx_pkg::ADDR_EXT_PORT_DATA_CLEAR, gpx_pkg::ADDR_EXT_PORT_DIRECTION,
    gpx_pkg::ADDR_EXT_PORT_DIRECTION_SET, gpx_pkg::ADDR_EXT_PORT_DIRECTION_CLEAR,
    gpx_pkg::ADDR_EXT_PORT_OPEN_DRAIN, gpx_pkg::ADDR_EXT_PORT_OPEN_DRAIN_SET,
    gpx_pkg::ADDR_EXT_PORT_OPEN_DRAIN_CLEAR};

  // -------------------------------------------------------------------------
  // Register access, capture sampling and latch merging.
  // -------------------------------------------------------------------------
  // All registers accept whole words only; per-bit change on the extension port goes through set/clear.
  always_comb begin
    st_d = st_q;
    st_d.hit = 1'b0;
    st_d.rdata = 16'h0000;
    // Capture sampler: one sample every 200 ns.
    if (st_q.samp_cnt == gpx_pkg::SAMPLE_LAST) begin
      st_d.samp_cnt = 6'h00;
      st_d.cap_hi = p7_lvl[7:4];
      st_d.cap_lo = p8_lvl;
    end else begin
      st_d.samp_cnt = st_q.samp_cnt + 6'h01;
    end
    // Compare data loads the second port latch ahead of bus writes.
    st_d.p8_data = (st_q.p8_data & ~cc_port_alt_load) | (cc_port_alt_out & cc_port_alt_load);
    if (reg_wr) begin
      st_d.hit = 1'b1;
      case (reg_addr)
        gpx_pkg::ADDR_PWM_CC_PORT_DATA: st_d.p7_data = reg_wdata[7:0];
        gpx_pkg::ADDR_PWM_CC_PORT_DIRECTION: st_d.p7_dir = reg_wdata[7:0];
        gpx_pkg::ADDR_PWM_CC_PORT_OPEN_DRAIN: st_d.p7_od = reg_wdata[7:0];
        gpx_pkg::ADDR_CC_PORT_DATA: st_d.p8_data = reg_wdata[7:0];
        gpx_pkg::ADDR_CC_PORT_DIRECTION: st_d.p8_dir = reg_wdata[7:0];
        gpx_pkg::ADDR_CC_PORT_OPEN_DRAIN: st_d.p8_od = reg_wdata[7:0];
        // Not a small port register: it answers only as an enabled extension register.
        default: st_d.hit = x_en & x_map;
      endcase
      // Extension writes land only while the port is enabled.
      if (x_en) begin
        case (reg_addr)
          gpx_pkg::ADDR_EXT_PORT_DATA: st_d.x_data = reg_wdata;
          gpx_pkg::ADDR_EXT_PORT_DATA_SET: st_d.x_data = st_q.x_data | reg_wdata;
          gpx_pkg::ADDR_EXT_PORT_DATA_CLEAR: st_d.x_data = st_q.x_data & ~reg_wdata;
          gpx_pkg::ADDR_EXT_PORT_DIRECTION: st_d.x_dir = reg_wdata;
          gpx_pkg::ADDR_EXT_PORT_DIRECTION_SET: st_d.x_dir = st_q.x_dir | reg_wdata;
          gpx_pkg::ADDR_EXT_PORT_DIRECTION_CLEAR: st_d.x_dir = st_q.x_dir & ~reg_wdata;
          gpx_pkg::ADDR_EXT_PORT_OPEN_DRAIN: st_d.x_od = reg_wdata;
          gpx_pkg::ADDR_EXT_PORT_OPEN_DRAIN_SET: st_d.x_od = st_q.x_od | reg_wdata;
          gpx_pkg::ADDR_EXT_PORT_OPEN_DRAIN_CLEAR: st_d.x_od = st_q.x_od & ~reg_wdata;
          default: st_d.hit = st_d.hit;
        endcase
      end
    end else if (reg_rd) begin
      st_d.hit = 1'b1;
      case (reg_addr)
        gpx_pkg::ADDR_PWM_CC_PORT_DATA: st_d.rdata = {8'h00, (p7_lvl & ~st_q.p7_dir) | (st_q.p7_data & st_q.p7_dir)};
        gpx_pkg::ADDR_PWM_CC_PORT_DIRECTION: st_d.rdata = {8'h00, st_q.p7_dir};
        gpx_pkg::ADDR_PWM_CC_PORT_OPEN_DRAIN: st_d.rdata = {8'h00, st_q.p7_od};
        gpx_pkg::ADDR_CC_PORT_DATA: st_d.rdata = {8'h00, (p8_lvl & ~st_q.p8_dir) | (st_q.p8_data & st_q.p8_dir)};
        gpx_pkg::ADDR_CC_PORT_DIRECTION: st_d.rdata = {8'h00, st_q.p8_dir};
        gpx_pkg::ADDR_CC_PORT_OPEN_DRAIN: st_d.rdata = {8'h00, st_q.p8_od};
        // Not a small port register: it answers only as an enabled extension register.
        default: st_d.hit = x_en & x_map;
      endcase
      // Extension reads return data only while the port is enabled, else zero.
      if (x_en) begin
        case (reg_addr)
          gpx_pkg::ADDR_EXT_PORT_DATA: st_d.rdata = (x_lvl & ~st_q.x_dir) | (st_q.x_data & st_q.x_dir);
          gpx_pkg::ADDR_EXT_PORT_DIRECTION: st_d.rdata = st_q.x_dir;
          gpx_pkg::ADDR_EXT_PORT_OPEN_DRAIN: st_d.rdata = st_q.x_od;
          // Set and clear registers are write-only and read as zero.
          gpx_pkg::ADDR_EXT_PORT_DATA_SET, gpx_pkg::ADDR_EXT_PORT_DATA_CLEAR,
          gpx_pkg::ADDR_EXT_PORT_DIRECTION_SET, gpx_pkg::ADDR_EXT_PORT_DIRECTION_CLEAR,
          gpx_pkg::ADDR_EXT_PORT_OPEN_DRAIN_SET, gpx_pkg::ADDR_EXT_PORT_OPEN_DRAIN_CLEAR: st_d.rdata = 16'h0000;
          default: st_d.hit = st_d.hit;
        endcase
      end
    end
  end

  // Register the whole state, frozen while the enable is low.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.p7_data <= gpx_pkg::RESET_SMALL;
      st_q.x_data <= gpx_pkg::RESET_EXT;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // -------------------------------------------------------------------------
  // Pin drivers.
  // -------------------------------------------------------------------------
  // Per-line value and driver mode, one generate loop for both small ports and one for the extension port.
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_small
      if (i < 4) begin : g_pwm
        assign p7_val[i] = st_q.p7_data[i] ^ pwm_channel_out[i];
      end else begin : g_cc
        assign p7_val[i] = st_q.p7_data[i] & (cc_hi_alt_en[i-4] ? cc_hi_alt_out[i-4] : 1'b1);
      end
      assign p8_val[i] = st_q.p8_data[i];
      // Open-drain lines drive only a low level.
      assign pwm_cc_pin_oe[i] = st_q.p7_dir[i] & (~st_q.p7_od[i] | ~p7_val[i]);
      assign pwm_cc_pin_out[i] = p7_val[i];
      assign cc_pin_oe[i] = st_q.p8_dir[i] & (~st_q.p8_od[i] | ~p8_val[i]);
      assign cc_pin_out[i] = p8_val[i];
    end
    for (i = 0; i < 16; i++) begin : g_ext
      assign x_val[i] = st_q.x_data[i];
      assign ext_pin_oe[i] = x_en & st_q.x_dir[i] & (~st_q.x_od[i] | ~x_val[i]);
      assign ext_pin_out[i] = x_val[i];
    end
  endgenerate

  assign reg_rdata = st_q.rdata;
  assign reg_hit = st_q.hit;
  assign cc_hi_capture_in = st_q.cap_hi;
  assign cc_port_capture_in = st_q.cap_lo;

  // -------------------------------------------------------------------------
  // Checks.
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_set_bits: assert property (ce && reg_wr && x_en && reg_addr == gpx_pkg::ADDR_EXT_PORT_DATA_SET |=>
    ((st_q.x_data & $past(reg_wdata)) == $past(reg_wdata))) else $error("data set missed a bit");
  chk_clr_bits: assert property (ce && reg_wr && x_en && reg_addr == gpx_pkg::ADDR_EXT_PORT_DATA_CLEAR |=>
    ((st_q.x_data & $past(reg_wdata)) == 16'h0000)) else $error("data clear missed a bit");
  chk_dir_set: assert property (ce && reg_wr && x_en && reg_addr == gpx_pkg::ADDR_EXT_PORT_DIRECTION_SET |=>
    (st_q.x_dir == ($past(st_q.x_dir) | $past(reg_wdata)))) else $error("direction set wrong");
  chk_ext_gate: assert property (!x_en |-> ext_pin_oe == 16'h0000) else $error("extension drives while off");
  chk_in_hiz: assert property ((pwm_cc_pin_oe & ~st_q.p7_dir) == 8'h00) else $error("input line driven");
  chk_od_low: assert property ((cc_pin_oe & st_q.p8_od & cc_pin_out) == 8'h00) else $error("open drain drove high");
  chk_pwm_xor: assert property (pwm_cc_pin_out[3:0] == (st_q.p7_data[3:0] ^ pwm_channel_out)) else $error("pwm xor");
  chk_ext_od: assert property ((ext_pin_oe & st_q.x_od & ext_pin_out) == 16'h0000) else $error("ext od high");
  chk_samp_period: assert property (ce && st_q.samp_cnt == 6'h00 |=> st_q.samp_cnt == 6'h01) else $error("sampler");
  // An extension register access while the port is off gets no answer.
  chk_ext_off_hit: assert property (ce && (reg_wr || reg_rd) && x_map && !x_en |=> !reg_hit)
    else $error("extension answered while off");
  // The extension latch cannot move while the port is off.
  chk_ext_off_hold: assert property (ce && !x_en |=> st_q.x_data == $past(st_q.x_data))
    else $error("extension data moved while off");
  // Clearing open-drain bits leaves every written one at zero.
  chk_od_clear: assert property (ce && reg_wr && x_en && reg_addr == gpx_pkg::ADDR_EXT_PORT_OPEN_DRAIN_CLEAR |=>
    ((st_q.x_od & $past(reg_wdata)) == 16'h0000)) else $error("open drain clear missed a bit");
  // A compare load with no bus write takes the compare value into the latch.
  chk_cc_load: assert property (ce && cc_port_alt_load[0] && !(reg_wr && reg_addr == gpx_pkg::ADDR_CC_PORT_DATA) |=>
    st_q.p8_data[0] == $past(cc_port_alt_out[0])) else $error("compare load missed");
  // A bus write to the second port latch wins over any compare load.
  chk_bus_wins: assert property (ce && reg_wr && reg_addr == gpx_pkg::ADDR_CC_PORT_DATA |=>
    st_q.p8_data == $past(reg_wdata[7:0])) else $error("bus write lost to compare load");
  // A low enable freezes every register of the block.
  chk_ce_freeze: assert property (!ce |=> st_q == $past(st_q)) else $error("state moved with enable low");
  // Without an access the answer lines fall back to zero.
  chk_idle_quiet: assert property (ce && !reg_wr && !reg_rd |=> reg_rdata == 16'h0000 && !reg_hit)
    else $error("answer without access");

  cov_pwm_invert: cover property (st_q.p7_dir[0] && st_q.p7_data[0]);
  cov_ext_set: cover property (reg_wr && x_en && reg_addr == gpx_pkg::ADDR_EXT_PORT_DATA_SET);
  cov_cc_load: cover property (ce && cc_port_alt_load != 8'h00);
  cov_od_release: cover property (st_q.x_od[15] && st_q.x_dir[15] && st_q.x_data[15]);
endmodule // gpx_ports

// file: test/gpx_pin_model.sv
// Purpose: Board-side model that resolves every port pin from the driver enables.
// Assumes: Each line has a weak pull-up, and board devices drive only where enabled.
// Notes: A released, undriven line reads high and never holds an old value.
`timescale 1ns/1ps
module gpx_pin_model #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] pin_oe,
  input wire logic [WIDTH-1:0] far_val,
  input wire logic [WIDTH-1:0] far_en,
  output logic [WIDTH-1:0] pin_level
);
  // The port driver wins where enabled, then a board device, then the pull-up.
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & far_en & far_val) | (~pin_oe & ~far_en);
endmodule // gpx_pin_model

// file: test/tb_top.sv
// Purpose: Self-checking bench for the GPIO port block.
// Assumes: Pins are resolved by the board model; stimulus moves 1 ns after each rising edge.
// Notes: Board devices drive low on every released line unless a scenario says otherwise.
`timescale 1ns/1ps
module tb_top;
  // ---------------------------------------------------------------------------
  // Signals, design and board models.
  // ---------------------------------------------------------------------------
  logic clk, srst, ce, reg_wr, reg_rd, reg_hit, xpe, xen;
  logic [19:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, ext_out, ext_oe, ext_lvl, ext_fv, ext_fe;
  logic [7:0] p_out, p_oe, p_lvl, p_fv, p_fe, c_out, c_oe, c_lvl, c_fv, c_fe, c_alt, c_load, c_cap;
  logic [3:0] pwm, hi_alt, hi_en, hi_cap;
  int fails, num_checks, cycles;
  gpx_ports u_dut (.clk(clk), .srst(srst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .extension_peripheral_enable(xpe),
    .extension_port_enable(xen), .pwm_channel_out(pwm), .cc_hi_alt_out(hi_alt), .cc_hi_alt_en(hi_en),
    .cc_port_alt_out(c_alt), .cc_port_alt_load(c_load), .cc_hi_capture_in(hi_cap), .cc_port_capture_in(c_cap),
    .pwm_cc_pin_in(p_lvl), .pwm_cc_pin_out(p_out), .pwm_cc_pin_oe(p_oe), .cc_pin_in(c_lvl), .cc_pin_out(c_out),
    .cc_pin_oe(c_oe), .ext_pin_in(ext_lvl), .ext_pin_out(ext_out), .ext_pin_oe(ext_oe));
  gpx_pin_model #(.WIDTH(8)) u_pm_p (.pin_out(p_out), .pin_oe(p_oe), .far_val(p_fv), .far_en(p_fe), .pin_level(p_lvl));
  gpx_pin_model #(.WIDTH(8)) u_pm_c (.pin_out(c_out), .pin_oe(c_oe), .far_val(c_fv), .far_en(c_fe), .pin_level(c_lvl));
  gpx_pin_model #(.WIDTH(16)) u_pm_x (.pin_out(ext_out), .pin_oe(ext_oe), .far_val(ext_fv), .far_en(ext_fe),
    .pin_level(ext_lvl));
  // The 5 ns clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Cuts a hang short after far more cycles than the scenarios need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      final_report();
    end
  end
  task automatic final_report();
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One access: an edge passes first, so a strobe never changes twice in one step; the strobe is held
  // across the taking edge and the registered answer is read just after it.
  task automatic acc(input logic w, input logic [19:0] a, input logic [15:0] d, output logic [15:0] q, output logic h);
    idle(1);
    reg_wr = w;
    reg_rd = ~w;
    reg_addr = a;
    reg_wdata = d;
    idle(1);
    q = reg_rdata;
    h = reg_hit;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic h;
    acc(1'b1, a, d, q, h);
  endtask
  task automatic rdc(input string n, input logic [19:0] a, input logic [15:0] e, input logic eh);
    logic [15:0] q;
    logic h;
    acc(1'b0, a, 16'h0000, q, h);
    check(n, e, q);
    check(n, {15'h0000, eh}, {15'h0000, h});
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    logic [19:0] rw [9] = '{gpx_pkg::ADDR_PWM_CC_PORT_DATA, gpx_pkg::ADDR_PWM_CC_PORT_DIRECTION,
      gpx_pkg::ADDR_PWM_CC_PORT_OPEN_DRAIN, gpx_pkg::ADDR_CC_PORT_DATA, gpx_pkg::ADDR_CC_PORT_DIRECTION,
      gpx_pkg::ADDR_CC_PORT_OPEN_DRAIN, gpx_pkg::ADDR_EXT_PORT_DATA, gpx_pkg::ADDR_EXT_PORT_DIRECTION,
      gpx_pkg::ADDR_EXT_PORT_OPEN_DRAIN};
    foreach (rw[i]) rdc("reset value", rw[i], 16'h0000, 1'b1);
    rdc("unmapped", 20'h0C400, 16'h0000, 1'b0);
    rdc("set register read", gpx_pkg::ADDR_EXT_PORT_DATA_SET, 16'h0000, 1'b1);
    check("reset oe", 16'h0000, ext_oe | {p_oe, c_oe});
  endtask
  // Same checks on either small port; sel picks the second port.
  task automatic t_small(input logic [19:0] da, input logic [19:0] dd, input logic [19:0] ao, input logic sel);
    wr(dd, 16'h003C);
    wr(da, 16'h00A5);
    check("push pull oe", 16'h003C, {8'h00, sel ? c_oe : p_oe});
    check("driven out", 16'h0024, {8'h00, (sel ? c_out : p_out) & 8'h3C});
    wr(ao, 16'h00F0);
    check("open drain oe", 16'h001C, {8'h00, sel ? c_oe : p_oe});
    rdc("open drain reg", ao, 16'h00F0, 1'b1);
    rdc("mixed data read", da, 16'h0024, 1'b1);
    wr(ao, 16'h0000);
    wr(dd, 16'h0000);
    wr(da, 16'h0000);
  endtask
  task automatic t_pwm();
    wr(gpx_pkg::ADDR_PWM_CC_PORT_DIRECTION, 16'h00FF);
    wr(gpx_pkg::ADDR_PWM_CC_PORT_DATA, 16'h0035);
    pwm = 4'h3; // The PWM channels count as enabled by software upstream.
    hi_alt = 4'hA;
    hi_en = 4'hF;
    #1;
    check("xor and out", 16'h0026, {8'h00, p_out});
    pwm = 4'hC;
    hi_en = 4'h5;
    idle(50);
    check("xor partial and", 16'h0029, {8'h00, p_out});
    check("high capture", 16'h0002, {12'h000, hi_cap});
    wr(gpx_pkg::ADDR_PWM_CC_PORT_DIRECTION, 16'h0000);
    pwm = 4'h0;
    hi_en = 4'h0;
  endtask
  task automatic t_cc();
    wr(gpx_pkg::ADDR_CC_PORT_DIRECTION, 16'h00FF);
    c_alt = 8'h5A;
    c_load = 8'h0F;
    idle(1);
    c_load = 8'h00;
    check("compare load", 16'h000A, {8'h00, c_out});
    c_alt = 8'h00;
    c_load = 8'hFF;
    wr(gpx_pkg::ADDR_CC_PORT_DATA, 16'h0081);
    c_load = 8'h00;
    rdc("bus over load", gpx_pkg::ADDR_CC_PORT_DATA, 16'h0081, 1'b1);
    wr(gpx_pkg::ADDR_CC_PORT_DIRECTION, 16'h0000);
    c_fv = 8'hC3;
    idle(50);
    check("port capture", 16'h00C3, {8'h00, c_cap});
    rdc("input read", gpx_pkg::ADDR_CC_PORT_DATA, 16'h00C3, 1'b1);
    c_fv = 8'h00;
  endtask
  task automatic t_ext();
    logic [1:0] en;
    wr(gpx_pkg::ADDR_EXT_PORT_DIRECTION_SET, 16'hFF00);
    wr(gpx_pkg::ADDR_EXT_PORT_DIRECTION_CLEAR, 16'h0F00);
    wr(gpx_pkg::ADDR_EXT_PORT_DATA_SET, 16'hA0F0);
    wr(gpx_pkg::ADDR_EXT_PORT_DATA_CLEAR, 16'h2030);
    wr(gpx_pkg::ADDR_EXT_PORT_OPEN_DRAIN_SET, 16'hC000);
    wr(gpx_pkg::ADDR_EXT_PORT_OPEN_DRAIN_CLEAR, 16'h4000);
    rdc("ext direction", gpx_pkg::ADDR_EXT_PORT_DIRECTION, 16'hF000, 1'b1);
    rdc("ext open drain", gpx_pkg::ADDR_EXT_PORT_OPEN_DRAIN, 16'h8000, 1'b1);
    rdc("ext data", gpx_pkg::ADDR_EXT_PORT_DATA, 16'h8000, 1'b1);
    check("ext oe", 16'h7000, ext_oe);
    check("ext out", 16'h8000, ext_out & 16'hF000);
    for (int i = 0; i < 3; i++) begin
      en = 2'(i);
      xpe = en[0];
      xen = en[1];
      wr(gpx_pkg::ADDR_EXT_PORT_DATA_SET, 16'h4000);
      rdc("ext disabled", gpx_pkg::ADDR_EXT_PORT_DATA, 16'h0000, 1'b0);
    end
    xpe = 1'b1;
    xen = 1'b1;
    ce = 1'b0;
    wr(gpx_pkg::ADDR_EXT_PORT_DATA_SET, 16'h2000);
    ce = 1'b1;
    rdc("ext unchanged", gpx_pkg::ADDR_EXT_PORT_DATA, 16'h8000, 1'b1);
    srst = 1'b1;
    idle(1);
    srst = 1'b0;
    rdc("second reset", gpx_pkg::ADDR_EXT_PORT_DIRECTION, 16'h0000, 1'b1);
  endtask
  // Main sequence: time-zero values, two reset cycles, then every scenario.
  initial begin
    {srst, ce, xpe, xen} = 4'hF;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {pwm, hi_alt, hi_en, c_alt, c_load} = '0;
    {p_fv, c_fv, ext_fv} = '0;
    {p_fe, c_fe, ext_fe} = '1;
    idle(2);
    srst = 1'b0;
    t_reset();
    t_small(gpx_pkg::ADDR_PWM_CC_PORT_DATA, gpx_pkg::ADDR_PWM_CC_PORT_DIRECTION, gpx_pkg::ADDR_PWM_CC_PORT_OPEN_DRAIN,
      1'b0);
    t_small(gpx_pkg::ADDR_CC_PORT_DATA, gpx_pkg::ADDR_CC_PORT_DIRECTION, gpx_pkg::ADDR_CC_PORT_OPEN_DRAIN, 1'b1);
    t_pwm();
    t_cc();
    t_ext();
    final_report();
  end
endmodule // tb_top
